//--- pcs_cfg.svh
// pcs_cfg.svh: constants of the clock select and input monitor block
// assumes inclusion by bare name from the clock generator, debounce and top modules
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
// clock rates
`define CLK_SYS_MHZ 40
`define OSC16_MHZ 16
`define OSC16_HZ 16000000
`define TICK32_HZ 32768
`define TRIM_DIV (`OSC16_HZ / `TICK32_HZ)
// times in microseconds, turned into 32 kHz ticks rounding up
`define OV_DEB_US 122
`define SEQ_FAST_US 500
`define SEQ_SLOW_US 2000
`define US_TO_TICKS(us) ((((us) * `TICK32_HZ) + 999999) / 1000000)
`define DEB_DEF_TICKS 16
`define SEQ_SLOTS 8
// register offsets
`define ADDR_IRQ_STAT 8'h00
`define ADDR_IRQ_MASK 8'h04
`define ADDR_SENSE 8'h08
`define ADDR_LDO_CTL 8'h0C
`define ADDR_SW_DIV 8'h10
`define ADDR_STATE 8'h14
// reset values
`define MASK_RST 3'h7
`define CTL_RST 3'h0
`define SW_DIV_RST 8'h08
// field positions
`define IRQ_LOWIN 0
`define IRQ_BTN 1
`define IRQ_OV 2
`define CTL_STBY_LP_DIS 0
`define CTL_BTN_CFG 1
`define CTL_SEQ_SLOW 2
// synchroniser lanes, also sense register bits 0..2
`define PIN_UV 0
`define PIN_DROOP 1
`define PIN_OV 2
`define PIN_LOWIN 3
`define PIN_BTN 4
`define PIN_COUNT 5
`endif

//--- pcs_pkg.sv
// pcs_pkg: types shared by the clock select and input monitor block
// assumes pcs_cfg.svh is compiled alongside
package pcs_pkg;
  typedef enum logic [1:0] {CLK_TRIM16, CLK_TICK32, CLK_RAW32} pcs_clk_sel_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} pcs_seq_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pcs_bus_t;
  typedef struct packed {
    logic standby;
    logic sleep;
  } pcs_mode_t;
  typedef struct packed {
    logic lowPower;
    logic extGateEn;
  } pcs_ldo_t;
endpackage

//--- pcs_clk_gen.sv
// pcs_clk_gen: trimmed 16 MHz enable, derived 32 kHz tick, switching
// enable and untrimmed 32 kHz tick; assumes osc32Raw is asynchronous
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module pcs_clk_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // divider setting and raw oscillator pin
  input wire logic [7:0] swDiv,
  input wire logic osc32Raw,
  // one-cycle enables
  output logic tickTrim,
  output logic tickRaw,
  output logic swClkEn
);
  typedef struct packed {
    logic [5:0] phase;
    logic [8:0] trimCnt;
    logic [7:0] swCnt;
    logic [2:0] rawSync;
    logic tickTrim;
    logic tickRaw;
    logic swClkEn;
  } pcs_gen_st_t;
  pcs_gen_st_t q, d;
  logic en16;
  logic [6:0] sum;
  logic [7:0] divEnd;

  // trimmed oscillator modelled by phase accumulation
  always_comb begin
    d = q;
    sum = 7'(q.phase) + 7'(`OSC16_MHZ);
    en16 = sum >= 7'(`CLK_SYS_MHZ);
    d.phase = en16 ? 6'(sum - 7'(`CLK_SYS_MHZ)) : 6'(sum);
    divEnd = (swDiv == 8'h00) ? 8'h00 : swDiv - 8'h01;
    d.tickTrim = 1'b0;
    d.swClkEn = 1'b0;
    if (en16) begin
      if (q.trimCnt == 9'(`TRIM_DIV - 1)) begin
        d.trimCnt = 9'h000;
        d.tickTrim = 1'b1;
      end else begin
        d.trimCnt = q.trimCnt + 9'h001;
      end
      if (q.swCnt >= divEnd) begin
        d.swCnt = 8'h00;
        d.swClkEn = 1'b1;
      end else begin
        d.swCnt = q.swCnt + 8'h01;
      end
    end
    d.rawSync = {q.rawSync[1], q.rawSync[0], osc32Raw};
    d.tickRaw = q.rawSync[1] & ~q.rawSync[2];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tickTrim = q.tickTrim;
  assign tickRaw = q.tickRaw;
  assign swClkEn = q.swClkEn;

  a_trim_tick_period: assert property (
    @(posedge clk_sys) disable iff (rst)
    tickTrim |-> $past(q.trimCnt) == 9'(`TRIM_DIV - 1))
    else $error("derived tick off its divider count");
  a_switch_from_trim: assert property (
    @(posedge clk_sys) disable iff (rst)
    swClkEn |-> $past(en16))
    else $error("switching enable without trimmed clock edge");
endmodule

//--- pcs_debounce.sv
// pcs_debounce: level filter counting ticks of a chosen time base
// assumes raw is already synchronous to clk_sys
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module pcs_debounce #(
  parameter int TICKS = 4
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // time base and input
  input wire logic tick,
  input wire logic raw,
  // filtered level
  output logic level
);
  localparam int CW = $clog2(TICKS + 1);
  if (TICKS < 1 || TICKS > 65535) begin : g_chk
    $error("debounce TICKS out of range");
  end
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } pcs_deb_st_t;
  pcs_deb_st_t q, d;

  // only whole ticks of stable input count
  always_comb begin
    d = q;
    if (raw == q.level) begin
      d.cnt = '0;
    end else if (tick) begin
      if (q.cnt == CW'(TICKS - 1)) begin
        d.level = raw;
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;

  a_deb_on_tick: assert property (
    @(posedge clk_sys) disable iff (rst)
    $changed(level) |-> $past(tick) && $past(raw) == level)
    else $error("filtered level moved off a tick");
endmodule

//--- pcs_top.sv
// pcs_top: clock source select, start-up sequencer, front-end regulator
// steering and overvoltage interrupt with plain register port.
// assumes pin inputs are asynchronous; mode and regulator state inputs
// come from logic on clk_sys.
//
// Operation
// - start-up steps advance only on the trimmed 32 kHz tick
// - each regulator turns on at its programmed slot, slot length software set; a regulator programmed to slot 0 is never turned on
// - two sources: trimmed 16 MHz clock and untrimmed 32 kHz oscillator
// - untrimmed source only under undervoltage, all asleep, or all in PFM
// - derived tick used in start-up and for button debounce when configured
// - in ON state overvoltage debounce counts derived 32 kHz ticks
// - low-input debounce, and button debounce by default, run on untrimmed oscillator
// - switching enables divide the trimmed 16 MHz clock
// - standby and sleep put front-end in low power, external pass off
// - disable bit keeps normal mode in standby, sleep still low power
// - input droop turns external pass gate drive off
// - overvoltage sets bit 2 of interrupt status
// - interrupt line low for overvoltage only while unmasked
// - overvoltage filtered by 122 us debounce before flagging
// - overvoltage during start-up raises no interrupt
// - live overvoltage sense bit readable by host
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module pcs_top #(
  parameter int NREG = 4,
  parameter int LOWIN_DEB_TICKS = `DEB_DEF_TICKS,
  parameter int BTN_DEB_TICKS = `DEB_DEF_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input pcs_pkg::pcs_bus_t bus,
  output logic [7:0] rdata,
  // asynchronous pins
  input wire logic osc32Raw,
  input wire logic vinUnderVolt,
  input wire logic vinDroop,
  input wire logic overvoltDetect,
  input wire logic lowInputRaw,
  input wire logic buttonRaw,
  // device state from the mode controller
  input pcs_pkg::pcs_mode_t mode,
  input wire logic [NREG-1:0] regSleep,
  input wire logic [NREG-1:0] regPfm,
  input wire logic startReq,
  input wire logic [NREG-1:0][2:0] otpSeq,
  // outputs
  output logic irq_out_n,
  output pcs_pkg::pcs_clk_sel_t clkSel,
  output logic [NREG-1:0] regEn,
  output logic seqBusy,
  output pcs_pkg::pcs_ldo_t ldo,
  output logic swClkEn
);
  if (NREG < 1 || NREG > 8) begin : g_chk
    $error("NREG must be 1 to 8");
  end

  typedef struct packed {
    logic [`PIN_COUNT-1:0] s1;
    logic [`PIN_COUNT-1:0] s2;
    logic [2:0] evPrev;
    logic [2:0] status;
    logic [2:0] mask;
    logic [2:0] ctl;
    logic [7:0] swDiv;
    logic [7:0] rdata;
    logic irqN;
    pcs_pkg::pcs_clk_sel_t clkSel;
    pcs_pkg::pcs_seq_t seq;
    logic [2:0] slot;
    logic [6:0] slotCnt;
    logic [NREG-1:0] regEn;
    pcs_pkg::pcs_ldo_t ldo;
    logic seqBusy;
  } pcs_top_st_t;
  pcs_top_st_t q, d;

  logic tickTrim, tickRaw;
  logic ovTick, btnTick;
  logic ovLvl, lowLvl, btnLvl;
  logic fallback;
  logic [2:0] evLvl, evSet;
  logic rdStat;

  // slot length in derived ticks for the chosen sequencer speed
  function automatic logic [6:0] seqTicks(input logic slow);
    seqTicks = slow ? 7'(`US_TO_TICKS(`SEQ_SLOW_US))
                    : 7'(`US_TO_TICKS(`SEQ_FAST_US));
  endfunction

  // regulators whose slot number matches
  function automatic logic [NREG-1:0] slotHits(
      input logic [NREG-1:0][2:0] seqs, input logic [2:0] slot);
    slotHits = '0;
    for (int i = 0; i < NREG; i++) begin
      slotHits[i] = (seqs[i] == slot) && (seqs[i] != 3'h0);
    end
  endfunction

  pcs_clk_gen u_clk_gen (
    .clk_sys(clk_sys),
    .rst(rst),
    .swDiv(q.swDiv),
    .osc32Raw(osc32Raw),
    .tickTrim(tickTrim),
    .tickRaw(tickRaw),
    .swClkEn(swClkEn)
  );

  // derived tick while trimmed clock runs, raw after fallback
  assign ovTick = (q.clkSel == pcs_pkg::CLK_RAW32) ? tickRaw : tickTrim;
  // button debounce on derived tick when configured
  assign btnTick = q.ctl[`CTL_BTN_CFG] ? tickTrim : tickRaw;

  // overvoltage filter length from 122 us
  pcs_debounce #(.TICKS(`US_TO_TICKS(`OV_DEB_US))) u_deb_ov (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(ovTick),
    .raw(q.s2[`PIN_OV]),
    .level(ovLvl)
  );

  pcs_debounce #(.TICKS(LOWIN_DEB_TICKS)) u_deb_low (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tickRaw),
    .raw(q.s2[`PIN_LOWIN]),
    .level(lowLvl)
  );

  // button filter on untrimmed oscillator by default
  pcs_debounce #(.TICKS(BTN_DEB_TICKS)) u_deb_btn (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(btnTick),
    .raw(q.s2[`PIN_BTN]),
    .level(btnLvl)
  );

  always_comb begin
    d = q;
    // pins pass two flops before any use
    d.s1 = {buttonRaw, lowInputRaw, overvoltDetect, vinDroop, vinUnderVolt};
    d.s2 = q.s1;

    fallback = q.s2[`PIN_UV] | (&regSleep) | (&regPfm);
    if (fallback) begin
      d.clkSel = pcs_pkg::CLK_RAW32;
    end else if (q.seq == pcs_pkg::SEQ_RUN) begin
      d.clkSel = pcs_pkg::CLK_TICK32;
    end else begin
      d.clkSel = pcs_pkg::CLK_TRIM16;
    end

    // start-up sequencer
    case (q.seq)
      pcs_pkg::SEQ_IDLE: begin
        d.regEn = '0;
        if (startReq) begin
          d.seq = pcs_pkg::SEQ_RUN;
          d.slot = 3'h0;
          d.slotCnt = 7'h00;
        end
      end
      pcs_pkg::SEQ_RUN: begin
        if (!startReq) begin
          d.seq = pcs_pkg::SEQ_IDLE;
          d.regEn = '0;
        // steps paced by trimmed tick, held under undervoltage
        end else if (tickTrim && !q.s2[`PIN_UV]) begin
          // programmed slot times slot length of seqTicks derived ticks
          if (q.slotCnt == seqTicks(q.ctl[`CTL_SEQ_SLOW]) - 7'h01) begin
            d.slotCnt = 7'h00;
            d.slot = q.slot + 3'h1;
            d.regEn = q.regEn | slotHits(otpSeq, q.slot + 3'h1);
            if (q.slot == 3'(`SEQ_SLOTS - 2)) begin
              d.seq = pcs_pkg::SEQ_DONE;
            end
          end else begin
            d.slotCnt = q.slotCnt + 7'h01;
          end
        end
      end
      pcs_pkg::SEQ_DONE: begin
        if (!startReq) begin
          d.seq = pcs_pkg::SEQ_IDLE;
          d.regEn = '0;
        end
      end
      default: begin
        d.seq = pcs_pkg::SEQ_IDLE;
        d.regEn = '0;
      end
    endcase
    // busy kept in a flop so the port never glitches on decode
    d.seqBusy = (d.seq == pcs_pkg::SEQ_RUN);

    // interrupt events on rising filtered levels
    evLvl = {ovLvl, btnLvl, lowLvl};
    evSet = evLvl & ~q.evPrev;
    d.evPrev = evLvl;
    if (q.seq == pcs_pkg::SEQ_RUN) begin
      evSet[`IRQ_OV] = 1'b0;
    end
    // read clears, a new event in that cycle wins
    rdStat = bus.rd && (bus.addr == `ADDR_IRQ_STAT);
    d.status = (rdStat ? 3'h0 : q.status) | evSet;

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        `ADDR_IRQ_MASK: d.mask = bus.wdata[2:0];
        `ADDR_LDO_CTL: d.ctl = bus.wdata[2:0];
        `ADDR_SW_DIV: d.swDiv = bus.wdata;
        default: ;
      endcase
    end

    // register reads, data stand one cycle
    d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `ADDR_IRQ_STAT: d.rdata = {5'h00, q.status};
        `ADDR_IRQ_MASK: d.rdata = {5'h00, q.mask};
        `ADDR_SENSE: d.rdata = {5'h00, q.s2[2:0]};
        `ADDR_LDO_CTL: d.rdata = {5'h00, q.ctl};
        `ADDR_SW_DIV: d.rdata = q.swDiv;
        `ADDR_STATE: d.rdata = {4'h0, q.seq, q.clkSel};
        default: d.rdata = 8'h00;
      endcase
    end

    // line low only for unmasked pending bits
    d.irqN = ~|(d.status & ~d.mask);

    // low power in sleep, and in standby unless disabled
    d.ldo.lowPower = mode.sleep | (mode.standby & ~q.ctl[`CTL_STBY_LP_DIS]);
    // droop forces external gate drive off
    d.ldo.extGateEn = ~d.ldo.lowPower & ~q.s2[`PIN_DROOP];
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.mask <= `MASK_RST;
      q.ctl <= `CTL_RST;
      q.swDiv <= `SW_DIV_RST;
      q.irqN <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign irq_out_n = q.irqN;
  assign clkSel = q.clkSel;
  assign regEn = q.regEn;
  assign seqBusy = q.seqBusy;
  assign ldo = q.ldo;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_fallback_select: assert property (
    fallback |=> clkSel == pcs_pkg::CLK_RAW32)
    else $error("fallback condition did not select raw source");
  a_raw_only_fallback: assert property (
    clkSel == pcs_pkg::CLK_RAW32 |-> $past(fallback))
    else $error("raw source chosen without cause");
  a_seq_on_tick: assert property (
    ($past(q.seq) == pcs_pkg::SEQ_RUN && q.seq == pcs_pkg::SEQ_RUN
     && $changed(q.slotCnt)) |-> $past(tickTrim))
    else $error("sequencer moved without derived tick");
  a_ov_flagged: assert property (
    (ovLvl && !q.evPrev[`IRQ_OV] && q.seq != pcs_pkg::SEQ_RUN)
    |=> q.status[`IRQ_OV])
    else $error("overvoltage event not flagged");
  a_ov_startup_quiet: assert property (
    $rose(q.status[`IRQ_OV]) |-> $past(q.seq) != pcs_pkg::SEQ_RUN)
    else $error("overvoltage flagged during start-up");
  a_ov_sticky: assert property (
    $fell(q.status[`IRQ_OV])
    |-> $past(bus.rd) && $past(bus.addr) == `ADDR_IRQ_STAT)
    else $error("overvoltage status lost without a read");
  a_irq_masking: assert property (
    (q.status[`IRQ_OV] && !q.mask[`IRQ_OV]) |-> !irq_out_n)
    else $error("unmasked overvoltage does not pull line low");
  a_sense_read: assert property (
    (bus.rd && bus.addr == `ADDR_SENSE)
    |=> rdata[`PIN_OV] == $past(q.s2[`PIN_OV]))
    else $error("sense read shows wrong level");
  a_ldo_sleep: assert property (
    mode.sleep |=> ldo.lowPower && !ldo.extGateEn)
    else $error("sleep left front-end in normal mode");
  a_ldo_stby_dis: assert property (
    (mode.standby && !mode.sleep && q.ctl[`CTL_STBY_LP_DIS])
    |=> !ldo.lowPower)
    else $error("standby entered low power despite disable bit");
  a_droop_gate: assert property (
    q.s2[`PIN_DROOP] |=> !ldo.extGateEn)
    else $error("droop left external gate driven");
  // filters must count on the time base their source calls for
  a_ov_tick_sel: assert property (
    $changed(ovLvl)
    |-> ($past(q.clkSel) == pcs_pkg::CLK_RAW32 ? $past(tickRaw) : $past(tickTrim)))
    else $error("overvoltage filter counted on the wrong tick");
  a_lowin_raw_tick: assert property (
    $changed(lowLvl)
    |-> $past(tickRaw))
    else $error("low-input filter counted off the untrimmed tick");
  a_btn_tick_sel: assert property (
    $changed(btnLvl)
    |-> ($past(q.ctl[`CTL_BTN_CFG]) ? $past(tickTrim) : $past(tickRaw)))
    else $error("button filter counted on the wrong tick");
  a_tick_in_start: assert property (
    (q.seq == pcs_pkg::SEQ_RUN && !fallback)
    |=> clkSel == pcs_pkg::CLK_TICK32)
    else $error("start-up did not use the derived tick");
  a_ov_filtered: assert property (
    $rose(q.status[`IRQ_OV])
    |-> $past(ovLvl) && !$past(q.evPrev[`IRQ_OV]))
    else $error("overvoltage flagged without a filtered onset");
  a_regen_at_slot: assert property (
    ($past(q.seq) == pcs_pkg::SEQ_RUN && regEn != $past(regEn))
    |-> (($past(tickTrim) && q.slotCnt == 7'h00) || q.seq == pcs_pkg::SEQ_IDLE))
    else $error("regulator enable moved off a slot boundary");
  a_regen_idle: assert property (
    q.seq == pcs_pkg::SEQ_IDLE |-> regEn == '0)
    else $error("regulator enabled while sequencer idle");
  a_irq_any_unmasked: assert property (
    ((q.status & ~q.mask) != 3'h0) == !irq_out_n)
    else $error("line level disagrees with pending unmasked bits");
endmodule

//--- pcs_host_model.sv
// pcs_host_model: host side of the plain register port and interrupt line
// assumes one clk_sys domain and a slave that never stalls
`timescale 1ns/100ps
module pcs_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output pcs_pkg::pcs_bus_t bus,
  input wire logic [7:0] rdata,
  // interrupt line
  input wire logic irq_out_n
);
  initial begin
    bus = '0;
  end
  // strobe released at the sampling edge, so a following call starts one edge later
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    d = rdata;
  endtask
  // bounded wait for the line to go low
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (irq_out_n !== 1'b0 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
endmodule

//--- test_pcs_top.sv
// test_pcs_top: register, clock select, front-end and interrupt tests
// assumes the host model drives the port; pins are driven from here
`timescale 1ns/100ps
module test_pcs_top;
  localparam int LIMIT = 80000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic osc32Raw = 1'b0;
  logic rawRun = 1'b1;
  logic vinUnderVolt = 1'b0;
  logic vinDroop = 1'b0;
  logic overvoltDetect = 1'b0;
  logic lowInputRaw = 1'b0;
  logic buttonRaw = 1'b0;
  pcs_pkg::pcs_bus_t bus;
  logic [7:0] rdata;
  pcs_pkg::pcs_mode_t mode = '0;
  logic [3:0] regSleep = 4'h0;
  logic [3:0] regPfm = 4'h0;
  logic startReq = 1'b0;
  logic [3:0][2:0] otpSeq = '0;
  logic irq_out_n;
  logic seqBusy;
  logic swClkEn;
  logic [3:0] regEn;
  pcs_pkg::pcs_clk_sel_t clkSel;
  pcs_pkg::pcs_ldo_t ldo;
  int failures = 0;
  int nTests = 0;
  int cycles = 0;
  int n;

  always #12.5 clk_sys = ~clk_sys;
  // free-running untrimmed oscillator, unrelated in phase
  always #15259 if (rawRun) osc32Raw = ~osc32Raw;

  pcs_host_model host (
    .clk_sys(clk_sys), .bus(bus), .rdata(rdata), .irq_out_n(irq_out_n)
  );

  // short debounce counts keep the run brief
  pcs_top #(.NREG(4), .LOWIN_DEB_TICKS(2), .BTN_DEB_TICKS(2)) uut (
    .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .osc32Raw(osc32Raw),
    .vinUnderVolt(vinUnderVolt), .vinDroop(vinDroop), .overvoltDetect(overvoltDetect),
    .lowInputRaw(lowInputRaw), .buttonRaw(buttonRaw), .mode(mode), .regSleep(regSleep),
    .regPfm(regPfm), .startReq(startReq), .otpSeq(otpSeq), .irq_out_n(irq_out_n),
    .clkSel(clkSel), .regEn(regEn), .seqBusy(seqBusy), .ldo(ldo), .swClkEn(swClkEn)
  );

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.read_reg(a, d);
    check(nm, d, e);
  endtask

  task automatic settle;
    repeat (5) @(posedge clk_sys);
  endtask

  // 400 cycles hold exactly 160 trimmed edges
  task automatic count_sw(input logic [7:0] e);
    int k;
    k = 0;
    repeat (400) begin
      @(posedge clk_sys);
      if (swClkEn === 1'b1) k++;
    end
    check("switch pulses", 8'(k), e);
  endtask

  task automatic fe(input logic sb, input logic sl, input logic dr, input logic [1:0] e);
    mode <= '{standby: sb, sleep: sl};
    vinDroop <= dr;
    settle();
    check("front end", 8'(ldo), {6'h00, e});
  endtask

  task automatic cs(input logic uv, input logic [3:0] sl, input logic [3:0] pf,
                    input pcs_pkg::pcs_clk_sel_t e);
    vinUnderVolt <= uv;
    regSleep <= sl;
    regPfm <= pf;
    settle();
    check("clock select", 8'(clkSel), 8'(e));
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("status", 8'h00, 8'h00);
    rdchk("mask", 8'h04, 8'h07);
    rdchk("sense", 8'h08, 8'h00);
    rdchk("control", 8'h0C, 8'h00);
    rdchk("divider", 8'h10, 8'h08);
    rdchk("unmapped", 8'h20, 8'h00);
    check("clock idle", 8'(clkSel), 8'(pcs_pkg::CLK_TRIM16));
    count_sw(8'h14);
    host.write_reg(8'h10, 8'h04);
    count_sw(8'h28);
    fe(1'b0, 1'b0, 1'b0, 2'h1);
    fe(1'b1, 1'b0, 1'b0, 2'h2);
    fe(1'b0, 1'b1, 1'b0, 2'h2);
    fe(1'b0, 1'b0, 1'b1, 2'h0);
    host.write_reg(8'h0C, 8'h01);
    rdchk("control", 8'h0C, 8'h01);
    fe(1'b1, 1'b0, 1'b0, 2'h1);
    fe(1'b0, 1'b1, 1'b0, 2'h2);
    fe(1'b0, 1'b0, 1'b0, 2'h1);
    cs(1'b1, 4'h0, 4'h0, pcs_pkg::CLK_RAW32);
    cs(1'b0, 4'hF, 4'h0, pcs_pkg::CLK_RAW32);
    cs(1'b0, 4'h0, 4'hF, pcs_pkg::CLK_RAW32);
    cs(1'b0, 4'h7, 4'h8, pcs_pkg::CLK_TRIM16);
    cs(1'b0, 4'h0, 4'h0, pcs_pkg::CLK_TRIM16);
    // low-input and button events on the untrimmed base
    host.write_reg(8'h04, 8'h04);
    lowInputRaw <= 1'b1;
    buttonRaw <= 1'b1;
    host.wait_irq(8000, n);
    check("low input line", {7'h00, irq_out_n}, 8'h00);
    repeat (3000) @(posedge clk_sys);
    rdchk("status", 8'h00, 8'h03);
    lowInputRaw <= 1'b0;
    buttonRaw <= 1'b0;
    settle();
    check("line cleared", {7'h00, irq_out_n}, 8'h01);
    // overvoltage outside start-up
    host.write_reg(8'h04, 8'h03);
    overvoltDetect <= 1'b1;
    settle();
    rdchk("sense", 8'h08, 8'h04);
    repeat (2400) @(posedge clk_sys);
    check("early line", {7'h00, irq_out_n}, 8'h01);
    rdchk("early status", 8'h00, 8'h00);
    host.wait_irq(6000, n);
    check("ov line", {7'h00, irq_out_n}, 8'h00);
    overvoltDetect <= 1'b0;
    settle();
    rdchk("sense", 8'h08, 8'h00);
    check("held line", {7'h00, irq_out_n}, 8'h00);
    host.write_reg(8'h04, 8'h07);
    settle();
    check("masked line", {7'h00, irq_out_n}, 8'h01);
    host.write_reg(8'h04, 8'h03);
    settle();
    check("unmasked line", {7'h00, irq_out_n}, 8'h00);
    rdchk("status", 8'h00, 8'h04);
    settle();
    check("cleared line", {7'h00, irq_out_n}, 8'h01);
    rdchk("status", 8'h00, 8'h00);
    // let the overvoltage filter fall so start-up sees a fresh onset
    repeat (5000) @(posedge clk_sys);
    // start-up with one regulator in slot 1
    otpSeq <= 12'h001;
    startReq <= 1'b1;
    n = 0;
    repeat (3) @(posedge clk_sys);
    check("busy", {7'h00, seqBusy}, 8'h01);
    check("start clock", 8'(clkSel), 8'(pcs_pkg::CLK_TICK32));
    rdchk("state", 8'h14, 8'h05);
    overvoltDetect <= 1'b1;
    repeat (6000) @(posedge clk_sys);
    check("ov in start", {7'h00, irq_out_n}, 8'h01);
    overvoltDetect <= 1'b0;
    n = 6005;
    while (regEn[0] !== 1'b1 && n < 25000) begin
      @(posedge clk_sys);
      n++;
    end
    check("slot time", 8'(n >= 19400 && n <= 21200), 8'h01);
    check("enables", 8'(regEn), 8'h01);
    check("still busy", {7'h00, seqBusy}, 8'h01);
    startReq <= 1'b0;
    settle();
    check("off enables", 8'(regEn), 8'h00);
    check("idle", {7'h00, seqBusy}, 8'h00);
    rdchk("status", 8'h00, 8'h00);
    // button on the derived tick while the untrimmed oscillator stands still
    host.write_reg(8'h0C, 8'h03);
    rawRun <= 1'b0;
    lowInputRaw <= 1'b1;
    buttonRaw <= 1'b1;
    repeat (3000) @(posedge clk_sys);
    rdchk("trim button", 8'h00, 8'h02);
    // slow slots: one regulator still off where a fast slot would have ended
    host.write_reg(8'h0C, 8'h04);
    startReq <= 1'b1;
    repeat (22000) @(posedge clk_sys);
    check("slow slot", 8'(regEn), 8'h00);
    check("slow busy", {7'h00, seqBusy}, 8'h01);
    startReq <= 1'b0;
    finish_test();
  end
endmodule
